// File: core/flash_regs_pkg.sv
// constants for the flash-disk host register bank
// assumes a byte-wide register window addressed by 13-bit offsets
package flash_regs_pkg;
  localparam int unsigned ADDR_W = 13;
  localparam logic [12:0] OFF_CHIP_IDENTITY    = 13'h1000;
  localparam logic [12:0] OFF_NO_OPERATION     = 13'h1002;
  localparam logic [12:0] OFF_SCRATCH_TEST     = 13'h1004;
  localparam logic [12:0] OFF_MODE_CONTROL     = 13'h1006;
  localparam logic [12:0] OFF_CASCADE_SELECT   = 13'h1008;
  localparam logic [12:0] OFF_DEVICE_CONFIG    = 13'h100A;
  localparam logic [12:0] OFF_OUTPUT_CONTROL   = 13'h100C;
  localparam logic [12:0] OFF_INTERRUPT_SETUP  = 13'h100E;
  localparam logic [12:0] OFF_PRESENCE_TOGGLE  = 13'h1046;
  localparam logic [12:0] OFF_MODE_CONFIRM     = 13'h1076;
  // identification code: arbitrary neutral value
  localparam logic [7:0] CHIP_IDENTITY_CODE    = 8'h5A;
  localparam logic [7:0] ZERO_BYTE             = 8'h00;
  localparam logic [7:0] SCRATCH_RESET         = 8'h00;
  localparam logic [7:0] MODE_CONTROL_RESET    = 8'h10;
  localparam logic [7:0] OUTPUT_CONTROL_RESET  = 8'h01;
  localparam logic [7:0] PRESENCE_BASE         = 8'h82;
  localparam logic [7:0] INTERRUPT_RESET       = 8'h00;
  // mode codes
  localparam logic [1:0] MODE_RESET            = 2'h0;
  localparam logic [1:0] MODE_NORMAL           = 2'h1;
  localparam logic [1:0] MODE_POWER_DOWN       = 2'h2;
  // field positions
  localparam int unsigned BIT_MODE_PERMIT      = 2;
  localparam int unsigned BIT_BOOT_DETECT      = 3;
  localparam int unsigned BIT_RESET_CAUSE      = 4;
  localparam int unsigned BIT_STICKY_LOCK      = 3;
  localparam int unsigned BIT_VIOL_ENABLE      = 3;
  localparam int unsigned BIT_EDGE_MODE        = 4;
  localparam int unsigned BIT_READY_FLAG       = 5;
  localparam int unsigned BIT_VIOL_FLAG        = 6;
  localparam int unsigned BIT_TOGGLE           = 2;
  localparam int unsigned BIT_IF_CONFIG        = 7;
  localparam logic [2:0] READY_SEL_OFF         = 3'h0;
  localparam logic [2:0] READY_SEL_ON          = 3'h1;
endpackage

// File: core/pin_sync.sv
// three-stage synchroniser for one level from outside the clock domain
// assumes a single clock; output changes once stages two and three agree
`timescale 1ns/100ps
module pin_sync
#(
  parameter logic INIT = 1'b0  // level shown while in reset
)
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // first stage is read only by the second
  always_ff @(posedge clk_i)
  begin
    s1_q <= pin_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // accept a change only when the last two stages agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      level_o <= INIT;
    else if (s2_q == s3_q)
      level_o <= s3_q;
  end
endmodule // pin_sync

// File: core/edge_pulse.sv
// rising-edge detector for a level already in the clock domain
// assumes the input comes from a synchroniser output
`timescale 1ns/100ps
module edge_pulse
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic level_i,
  output logic      rise_o
);
  logic last_q;

  // remember previous level to find a low-to-high change
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      last_q <= 1'b0;
      rise_o <= 1'b0;
    end
    else
    begin
      last_q <= level_i;
      rise_o <= level_i & ~last_q;
    end
  end
endmodule // edge_pulse

// File: core/flash_host_regs.sv
// host-visible control and status register bank of a flash disk
// assumes a synchronous byte bus: one-cycle rd/wr strobes with an offset;
// event pins (ready, violation, boot detect, reset, straps) are async
`timescale 1ns/100ps
// How it works
// - in reset mode every register read returns zero
// - identity register reads a fixed code outside reset mode
// - writes to the no-operation location change nothing
// - scratch register stores written byte, resets to zero, no side effect
// - control and confirm read identically, both reset to 10H
// - mode field: 00 reset, 01 normal, 10 deep power-down
// - confirmed mode writes apply only when their permit bit is one; forced resets set reset mode
// - boot detect flag sets on boot-forced reset, clears on write one
// - reset-cause flag sets on external or voltage reset, write-one clears
// - only the device whose id pins match the select answers
// - configuration cleared only by hardware reset
// - highest cascade id field drives boot-area mapping
// - configuration bit 7 mirrors interface configuration pin
// - sticky lock acts as lock until external reset, reads zero
// - ready select 000 keeps ready interrupt off, 001 interrupts on ready
// - violation enable makes protection violations interrupt
// - level mode holds interrupt low; edge mode emits a low pulse
// - ready flag records ready interrupt, write one clears and re-arms
// - violation flag records violation interrupt, write one clears
// - toggle bit inverts on every answered read of presence register outside reset mode
module flash_host_regs
  import flash_regs_pkg::*;
(
  // clock and hardware reset
  input  wire logic              CLK_I,
  input  wire logic              SYS_RST_I,
  // register bus
  input  wire logic [ADDR_W-1:0] ADDR_I,
  input  wire logic              RD_I,
  input  wire logic              WR_I,
  input  wire logic [7:0]        WDATA_I,
  input  wire logic              BOOT_READ_I,
  output logic      [7:0]        RDATA_O,
  output logic                   RVALID_O,
  // asynchronous pins and events
  input  wire logic              EXTERNAL_RESET_N_I,
  input  wire logic              VOLTAGE_DETECT_I,
  input  wire logic              BOOT_DETECT_I,
  input  wire logic              FLASH_READY_I,
  input  wire logic              PROT_VIOLATION_I,
  input  wire logic [1:0]        CASCADE_ID_I,
  input  wire logic              IF_CONFIG_I,
  // outputs
  output logic      [1:0]        MODE_O,
  output logic      [1:0]        HIGHEST_CASCADE_ID_O,
  output logic                   STICKY_LOCK_O,
  output logic                   IRQ_N_O
);
  typedef enum logic [1:0] {
    CF_IDLE    = 2'b01,
    CF_PENDING = 2'b10
  } confirm_state_t;

  confirm_state_t cf_q;
  logic [7:0] pend_q;
  logic [7:0] scratch_q;
  logic [1:0] mode_q;
  logic       permit_q;
  logic       boot_flag_q;
  logic       cause_flag_q;
  logic [1:0] cascade_select_q;
  logic [1:0] highest_id_q;
  logic       sticky_q;
  logic [2:0] ready_sel_q;
  logic       viol_en_q;
  logic       edge_q;
  logic       ready_flag_q;
  logic       viol_flag_q;
  logic       toggle_q;
  logic       irq_n_q;

  logic ext_rst_n_s, volt_s, boot_s, ready_s, viol_s, if_cfg_s;
  logic [1:0] id_s;
  logic ext_rst_rise, volt_rise, boot_rise;
  logic ready_rise, viol_rise;

  // synchronise every pin; ext reset rests high
  pin_sync #(.INIT(1'b1)) u_sync_rst (.clk_i(CLK_I), .rst_i(SYS_RST_I),
    .pin_i(EXTERNAL_RESET_N_I), .level_o(ext_rst_n_s));
  pin_sync u_sync_volt (.clk_i(CLK_I), .rst_i(SYS_RST_I),
    .pin_i(VOLTAGE_DETECT_I), .level_o(volt_s));
  pin_sync u_sync_boot (.clk_i(CLK_I), .rst_i(SYS_RST_I),
    .pin_i(BOOT_DETECT_I), .level_o(boot_s));
  pin_sync u_sync_rdy (.clk_i(CLK_I), .rst_i(SYS_RST_I),
    .pin_i(FLASH_READY_I), .level_o(ready_s));
  pin_sync u_sync_viol (.clk_i(CLK_I), .rst_i(SYS_RST_I),
    .pin_i(PROT_VIOLATION_I), .level_o(viol_s));
  pin_sync u_sync_cfg (.clk_i(CLK_I), .rst_i(SYS_RST_I),
    .pin_i(IF_CONFIG_I), .level_o(if_cfg_s));

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_id_sync
      pin_sync u_sync_id (.clk_i(CLK_I), .rst_i(SYS_RST_I),
        .pin_i(CASCADE_ID_I[gi]), .level_o(id_s[gi]));
    end
  endgenerate

  // event edges
  edge_pulse u_e_rst (.clk_i(CLK_I), .rst_i(SYS_RST_I),
    .level_i(~ext_rst_n_s), .rise_o(ext_rst_rise));
  edge_pulse u_e_volt (.clk_i(CLK_I), .rst_i(SYS_RST_I),
    .level_i(volt_s), .rise_o(volt_rise));
  edge_pulse u_e_boot (.clk_i(CLK_I), .rst_i(SYS_RST_I),
    .level_i(boot_s), .rise_o(boot_rise));
  edge_pulse u_e_rdy (.clk_i(CLK_I), .rst_i(SYS_RST_I),
    .level_i(ready_s), .rise_o(ready_rise));
  edge_pulse u_e_viol (.clk_i(CLK_I), .rst_i(SYS_RST_I),
    .level_i(viol_s), .rise_o(viol_rise));

  // decode helper, used for every register select
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  logic selected;
  logic wr_sel;
  logic rd_sel;
  logic forced_reset;
  logic in_reset_mode;
  logic [7:0] ctrl_view;
  logic [7:0] cfg_view;
  logic [7:0] irq_view;
  logic apply_ctrl;

  assign selected      = (id_s == cascade_select_q);
  assign wr_sel        = WR_I & selected;
  assign rd_sel        = RD_I & selected;
  assign forced_reset  = ext_rst_rise | volt_rise | boot_rise;
  assign in_reset_mode = (mode_q == MODE_RESET);
  assign ctrl_view     = {3'h0, cause_flag_q, boot_flag_q, permit_q,
                          mode_q};
  assign cfg_view      = {if_cfg_s, 1'b0, highest_id_q, 4'h0};
  assign irq_view      = {1'b0, viol_flag_q, ready_flag_q, edge_q,
                          viol_en_q, ready_sel_q};
  // confirm write must carry the exact complement of the pending byte
  assign apply_ctrl    = (cf_q == CF_PENDING) & wr_sel &
                         hit(ADDR_I, OFF_MODE_CONFIRM) &
                         (WDATA_I == ~pend_q);

  // two-write confirmation sequencer; any other access except a boot read cancels
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      cf_q   <= CF_IDLE;
      pend_q <= ZERO_BYTE;
    end
    else if (wr_sel & hit(ADDR_I, OFF_MODE_CONTROL))
    begin
      cf_q   <= CF_PENDING;
      pend_q <= WDATA_I;
    end
    else if ((WR_I | RD_I) & ~BOOT_READ_I)
      cf_q <= CF_IDLE;
  end

  // mode, permit and reset-cause flags
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      mode_q       <= MODE_CONTROL_RESET[1:0];
      permit_q     <= MODE_CONTROL_RESET[BIT_MODE_PERMIT];
      boot_flag_q  <= MODE_CONTROL_RESET[BIT_BOOT_DETECT];
      cause_flag_q <= MODE_CONTROL_RESET[BIT_RESET_CAUSE];
    end
    else
    begin
      if (forced_reset)
        mode_q <= MODE_RESET;
      else if (apply_ctrl & pend_q[BIT_MODE_PERMIT] &
               (pend_q[1:0] != 2'h3))
        mode_q <= pend_q[1:0];
      if (apply_ctrl)
        permit_q <= pend_q[BIT_MODE_PERMIT];
      // set wins over the write-one clear
      if (boot_rise)
        boot_flag_q <= 1'b1;
      else if (apply_ctrl & pend_q[BIT_BOOT_DETECT])
        boot_flag_q <= 1'b0;
      if (ext_rst_rise | volt_rise)
        cause_flag_q <= 1'b1;
      else if (apply_ctrl & pend_q[BIT_RESET_CAUSE])
        cause_flag_q <= 1'b0;
    end
  end

  // scratch, cascade select; the no-operation offset decodes to nothing
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      scratch_q        <= SCRATCH_RESET;
      cascade_select_q <= 2'h0;
    end
    else if (wr_sel & ~in_reset_mode)
    begin
      if (hit(ADDR_I, OFF_SCRATCH_TEST))
        scratch_q <= WDATA_I;
      if (hit(ADDR_I, OFF_CASCADE_SELECT))
        cascade_select_q <= WDATA_I[1:0];
    end
  end

  // configuration: only hardware reset clears it, not mode resets
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      highest_id_q <= 2'h0;
    else if (wr_sel & ~in_reset_mode & hit(ADDR_I, OFF_DEVICE_CONFIG))
      highest_id_q <= WDATA_I[5:4];
  end

  // sticky lock survives everything but hardware reset and the external reset pin
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      sticky_q <= OUTPUT_CONTROL_RESET[BIT_STICKY_LOCK];
    else if (ext_rst_rise)
      sticky_q <= 1'b0;
    else if (wr_sel & ~in_reset_mode & hit(ADDR_I, OFF_OUTPUT_CONTROL) &
             WDATA_I[BIT_STICKY_LOCK])
      sticky_q <= 1'b1;
  end

  logic ready_ev;
  logic viol_ev;
  logic clr_ready;
  logic clr_viol;
  logic irq_wr;
  assign irq_wr    = wr_sel & ~in_reset_mode &
                     hit(ADDR_I, OFF_INTERRUPT_SETUP);
  assign ready_ev  = ready_rise & (ready_sel_q == READY_SEL_ON) &
                     ~ready_flag_q;
  assign viol_ev   = viol_rise & viol_en_q & ~viol_flag_q;
  assign clr_ready = irq_wr & WDATA_I[BIT_READY_FLAG];
  assign clr_viol  = irq_wr & WDATA_I[BIT_VIOL_FLAG];

  // interrupt setup and flags; a new event beats the clear
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      ready_sel_q  <= INTERRUPT_RESET[2:0];
      viol_en_q    <= INTERRUPT_RESET[BIT_VIOL_ENABLE];
      edge_q       <= INTERRUPT_RESET[BIT_EDGE_MODE];
      ready_flag_q <= INTERRUPT_RESET[BIT_READY_FLAG];
      viol_flag_q  <= INTERRUPT_RESET[BIT_VIOL_FLAG];
    end
    else
    begin
      if (irq_wr)
      begin
        ready_sel_q <= WDATA_I[2:0];
        viol_en_q   <= WDATA_I[BIT_VIOL_ENABLE];
        edge_q      <= WDATA_I[BIT_EDGE_MODE];
      end
      if (ready_ev)
        ready_flag_q <= 1'b1;
      else if (clr_ready)
        ready_flag_q <= 1'b0;
      if (viol_ev)
        viol_flag_q <= 1'b1;
      else if (clr_viol)
        viol_flag_q <= 1'b0;
    end
  end

  // level mode follows the flags; edge mode gives one low cycle per event
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      irq_n_q <= 1'b1;
    else if (ready_sel_q == READY_SEL_OFF & ~viol_en_q)
      irq_n_q <= 1'b1;
    else if (edge_q)
      irq_n_q <= ~(ready_ev | viol_ev);
    else
      irq_n_q <= ~(ready_flag_q | viol_flag_q);
  end

  // toggle bit flips on each answered read of its register outside reset mode
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      toggle_q <= PRESENCE_BASE[BIT_TOGGLE];
    else if (rd_sel & ~in_reset_mode & hit(ADDR_I, OFF_PRESENCE_TOGGLE))
      toggle_q <= ~toggle_q;
  end

  // read mux, registered; unmapped and write-only offsets read zero
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      RDATA_O  <= ZERO_BYTE;
      RVALID_O <= 1'b0;
    end
    else
    begin
      RVALID_O <= rd_sel;
      if (~rd_sel | in_reset_mode)
        RDATA_O <= ZERO_BYTE;
      else if (hit(ADDR_I, OFF_CHIP_IDENTITY))
        RDATA_O <= CHIP_IDENTITY_CODE;
      else if (hit(ADDR_I, OFF_SCRATCH_TEST))
        RDATA_O <= scratch_q;
      else if (hit(ADDR_I, OFF_MODE_CONTROL) |
               hit(ADDR_I, OFF_MODE_CONFIRM))
        RDATA_O <= ctrl_view;
      else if (hit(ADDR_I, OFF_CASCADE_SELECT))
        RDATA_O <= {6'h00, cascade_select_q};
      else if (hit(ADDR_I, OFF_DEVICE_CONFIG))
        RDATA_O <= cfg_view;
      else if (hit(ADDR_I, OFF_OUTPUT_CONTROL))
        RDATA_O <= OUTPUT_CONTROL_RESET;
      else if (hit(ADDR_I, OFF_INTERRUPT_SETUP))
        RDATA_O <= irq_view;
      else if (hit(ADDR_I, OFF_PRESENCE_TOGGLE))
        RDATA_O <= {PRESENCE_BASE[7:3], toggle_q, PRESENCE_BASE[1:0]};
      else
        RDATA_O <= ZERO_BYTE;
    end
  end

  // registered pin outputs
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      MODE_O               <= MODE_CONTROL_RESET[1:0];
      HIGHEST_CASCADE_ID_O <= 2'h0;
      STICKY_LOCK_O        <= 1'b0;
    end
    else
    begin
      MODE_O               <= mode_q;
      HIGHEST_CASCADE_ID_O <= highest_id_q;
      STICKY_LOCK_O        <= sticky_q;
    end
  end
  assign IRQ_N_O = irq_n_q;

  a_confirm_apply: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    apply_ctrl & pend_q[BIT_MODE_PERMIT] & ~forced_reset &
    (pend_q[1:0] != 2'h3) |=> mode_q == $past(pend_q[1:0]))
    else $error("confirmed mode not applied");
  a_no_permit: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    ~forced_reset & ~(apply_ctrl & pend_q[BIT_MODE_PERMIT])
    |=> $stable(mode_q))
    else $error("mode changed without permit");
  a_reset_reads: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    rd_sel & in_reset_mode |=> RDATA_O == ZERO_BYTE)
    else $error("nonzero read in reset mode");
  a_id_read: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    rd_sel & ~in_reset_mode & hit(ADDR_I, OFF_CHIP_IDENTITY)
    |=> RDATA_O == CHIP_IDENTITY_CODE)
    else $error("identity code wrong");
  a_boot_flag: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    boot_rise |=> boot_flag_q & (mode_q == MODE_RESET))
    else $error("boot flag not set");
  a_cause_flag: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    ext_rst_rise |=> cause_flag_q & ~sticky_q)
    else $error("reset cause not latched");
  a_deselected: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    RD_I & ~selected |=> ~RVALID_O)
    else $error("unselected device answered");
  a_toggle_flip: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    rd_sel & ~in_reset_mode & hit(ADDR_I, OFF_PRESENCE_TOGGLE)
    |=> toggle_q != $past(toggle_q))
    else $error("toggle bit did not flip");
  a_edge_pulse: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    edge_q & ~irq_n_q & ~ready_ev & ~viol_ev & ~irq_wr |=> irq_n_q)
    else $error("edge interrupt longer than a cycle");
  a_ready_irq: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    ready_ev & ~edge_q & ~irq_wr |=> ready_flag_q ##1 ~irq_n_q)
    else $error("ready interrupt missing");
endmodule // flash_host_regs

// File: tb/host_bus_model.sv
// host processor model driving the register bank's byte bus
// assumes strobes are sampled on the rising clock edge, one cycle each
`timescale 1ns/100ps
module host_bus_model
  import flash_regs_pkg::*;
(
  // clock
  input  wire logic              clk_i,
  // bus toward the bank
  output logic      [ADDR_W-1:0] addr_o,
  output logic                   rd_o,
  output logic                   wr_o,
  output logic      [7:0]        wdata_o,
  output logic                   boot_o,
  input  wire logic [7:0]        rdata_i,
  input  wire logic              rvalid_i
);
  // idle bus at time zero
  initial
  begin
    addr_o = 13'h0000;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 8'h00;
    boot_o = 1'b0;
  end

  // data inverted after the strobe so a stale byte is never mistaken
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask

  // answer is sampled exactly one cycle after the read is taken
  task automatic rd(input logic [12:0] a, input logic b,
                    output logic [7:0] d, output logic v);
    @(posedge clk_i);
    addr_o <= a;
    boot_o <= b;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    boot_o <= 1'b0;
    @(posedge clk_i);
    d = rdata_i;
    v = rvalid_i;
  endtask

  // control byte then its complement, nothing in between
  task automatic pair(input logic [7:0] d);
    wr(OFF_MODE_CONTROL, d);
    wr(OFF_MODE_CONFIRM, ~d);
  endtask
endmodule // host_bus_model

// File: tb/flash_disk_host_control_registers_test.sv
// self-checking bench for the flash register bank
// assumes host_bus_model as the bus master; event pins driven here
`timescale 1ns/100ps
module flash_disk_host_control_registers_test;
  import flash_regs_pkg::*;
  logic              clk;
  logic              rst;
  logic [4:0]        ev_q;
  logic [1:0]        cid;
  logic              ifc;
  logic [ADDR_W-1:0] addr;
  logic              rd;
  logic              wr;
  logic              boot;
  logic [7:0]        wdata;
  logic [7:0]        rdata;
  logic              rvalid;
  logic [1:0]        mode;
  logic [1:0]        hid;
  logic              lock;
  logic              irq_n;
  logic [7:0]        r;
  logic [7:0]        r2;
  logic              v;
  int                err_total;
  int                n_checks;
  int                lows;

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  host_bus_model host (.clk_i(clk), .addr_o(addr), .rd_o(rd), .wr_o(wr),
    .wdata_o(wdata), .boot_o(boot), .rdata_i(rdata), .rvalid_i(rvalid));

  flash_host_regs dut (.CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr),
    .RD_I(rd), .WR_I(wr), .WDATA_I(wdata), .BOOT_READ_I(boot),
    .RDATA_O(rdata), .RVALID_O(rvalid), .EXTERNAL_RESET_N_I(~ev_q[4]),
    .VOLTAGE_DETECT_I(ev_q[3]), .BOOT_DETECT_I(ev_q[2]),
    .FLASH_READY_I(ev_q[0]), .PROT_VIOLATION_I(ev_q[1]),
    .CASCADE_ID_I(cid), .IF_CONFIG_I(ifc), .MODE_O(mode),
    .HIGHEST_CASCADE_ID_O(hid), .STICKY_LOCK_O(lock), .IRQ_N_O(irq_n));

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // masked read that must be answered
  task automatic rc(input logic [12:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    host.rd(a, 1'b0, r, v);
    chk({7'h00, v}, 8'h01);
    chk(r & m, e);
  endtask

  // mode output lands one edge after the confirm strobe is taken; checked three edges on
  task automatic mc(input logic [1:0] e);
    repeat (3) @(posedge clk);
    chk({6'h00, mode}, {6'h00, e});
  endtask

  // event pin held long enough to pass the synchroniser, irq lows counted
  task automatic ev(input int k);
    @(posedge clk);
    ev_q[k] <= 1'b1;
    repeat (3) @(posedge clk);
    ev_q[k] <= 1'b0;
    lows = 0;
    repeat (15)
    begin
      @(posedge clk);
      lows += (irq_n === 1'b0);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog: whole sequence needs well under 3000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    complete_run();
  end

  // main sequence
  initial
  begin
    rst = 1'b1;
    ev_q = 5'h00;
    cid = 2'h0;
    ifc = 1'b1;
    err_total = 0;
    n_checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rc(OFF_CHIP_IDENTITY, 8'hFF, 8'h00);
    rc(OFF_SCRATCH_TEST, 8'hFF, 8'h00);
    mc(MODE_RESET);
    host.pair(8'h05);
    mc(MODE_NORMAL);
    host.wr(OFF_CHIP_IDENTITY, 8'h33);
    rc(OFF_CHIP_IDENTITY, 8'hFF, CHIP_IDENTITY_CODE);
    rc(OFF_SCRATCH_TEST, 8'hFF, 8'h00);
    host.wr(OFF_SCRATCH_TEST, 8'hA5);
    host.wr(OFF_NO_OPERATION, 8'h5A);
    rc(OFF_SCRATCH_TEST, 8'hFF, 8'hA5);
    host.rd(OFF_MODE_CONTROL, 1'b0, r2, v);
    rc(OFF_MODE_CONFIRM, 8'hFF, r2);
    chk(r2 & 8'h13, 8'h11);
    $display("test basic registers done");
    host.pair(8'h02);
    mc(MODE_NORMAL);
    host.wr(OFF_MODE_CONTROL, 8'h06);
    host.wr(OFF_MODE_CONFIRM, 8'h00);
    mc(MODE_NORMAL);
    host.wr(OFF_MODE_CONTROL, 8'h06);
    host.rd(OFF_SCRATCH_TEST, 1'b0, r, v);
    host.wr(OFF_MODE_CONFIRM, 8'hF9);
    mc(MODE_NORMAL);
    host.wr(OFF_MODE_CONTROL, 8'h06);
    host.rd(13'h0010, 1'b1, r, v);
    host.wr(OFF_MODE_CONFIRM, 8'hF9);
    mc(MODE_POWER_DOWN);
    host.pair(8'h05);
    mc(MODE_NORMAL);
    host.pair(8'h07);
    mc(MODE_NORMAL);
    host.rd(OFF_PRESENCE_TOGGLE, 1'b0, r2, v);
    chk(r2, PRESENCE_BASE);
    rc(OFF_PRESENCE_TOGGLE, 8'hFF, r2 ^ 8'h04);
    $display("test mode protocol done");
    host.pair(8'h15);
    rc(OFF_MODE_CONTROL, 8'h10, 8'h00);
    ev(3);
    mc(MODE_RESET);
    rc(OFF_SCRATCH_TEST, 8'hFF, 8'h00);
    host.pair(8'h05);
    rc(OFF_MODE_CONTROL, 8'h10, 8'h10);
    host.wr(OFF_DEVICE_CONFIG, 8'h30);
    ev(2);
    mc(MODE_RESET);
    host.pair(8'h05);
    rc(OFF_MODE_CONTROL, 8'h08, 8'h08);
    chk({6'h00, hid}, 8'h03);
    rc(OFF_DEVICE_CONFIG, 8'h80, 8'h80);
    host.pair(8'h0D);
    rc(OFF_MODE_CONTROL, 8'h08, 8'h00);
    ifc <= 1'b0;
    repeat (6) @(posedge clk);
    rc(OFF_DEVICE_CONFIG, 8'h80, 8'h00);
    host.wr(OFF_OUTPUT_CONTROL, 8'h08);
    rc(OFF_OUTPUT_CONTROL, 8'hFF, 8'h01);
    chk({7'h00, lock}, 8'h01);
    ev(4);
    chk({7'h00, lock}, 8'h00);
    mc(MODE_RESET);
    host.pair(8'h05);
    $display("test reset causes done");
    // a mismatched cascade select must silence the bank
    host.wr(OFF_CASCADE_SELECT, 8'h01);
    host.rd(OFF_SCRATCH_TEST, 1'b0, r, v);
    chk({7'h00, v}, 8'h00);
    cid <= 2'h1;
    repeat (6) @(posedge clk);
    rc(OFF_CASCADE_SELECT, 8'h03, 8'h01);
    $display("test cascade done");
    host.wr(OFF_INTERRUPT_SETUP, 8'h01);
    ev(0);
    chk({7'h00, irq_n}, 8'h00);
    rc(OFF_INTERRUPT_SETUP, 8'h20, 8'h20);
    host.wr(OFF_INTERRUPT_SETUP, 8'h21);
    repeat (4) @(posedge clk);
    chk({7'h00, irq_n}, 8'h01);
    host.wr(OFF_INTERRUPT_SETUP, 8'h08);
    ev(1);
    chk({7'h00, irq_n}, 8'h00);
    rc(OFF_INTERRUPT_SETUP, 8'h40, 8'h40);
    host.wr(OFF_INTERRUPT_SETUP, 8'h48);
    repeat (4) @(posedge clk);
    chk({7'h00, irq_n}, 8'h01);
    host.wr(OFF_INTERRUPT_SETUP, 8'h11);
    ev(0);
    chk(lows[7:0], 8'h01);
    host.wr(OFF_INTERRUPT_SETUP, 8'h20);
    ev(0);
    chk(lows[7:0], 8'h00);
    ev(1);
    chk(lows[7:0], 8'h00);
    $display("test interrupts done");
    complete_run();
  end
endmodule // flash_disk_host_control_registers_test
